//--- pkg/jtm_pkg.sv
// jtm_pkg: constants and types for the test access port with memory access.
// assumes a five-bit instruction register and an 8-bit memory byte path.
package jtm_pkg;

  // ----------------------------------------------------------------
  // tap controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jtm_tap_t;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int          IR_W          = 5;
  localparam logic [4:0]  IR_CAPTURE    = 5'h01;
  localparam logic [4:0]  INS_IDCODE    = 5'h00;
  localparam logic [4:0]  INS_USERCODE  = 5'h03;
  localparam logic [4:0]  INS_LOAD_ADDR = 5'h04;
  localparam logic [4:0]  INS_READ      = 5'h05;
  localparam logic [4:0]  INS_WRITE     = 5'h06;
  localparam logic [4:0]  INS_REBOOT    = 5'h07;
  localparam logic [4:0]  INS_SAVE      = 5'h08;
  localparam logic [4:0]  flash_page_on_instr  = 5'h09;
  localparam logic [4:0]  flash_page_off_instr = 5'h0A;
  localparam logic [4:0]  user_page_on_instr   = 5'h0B;
  localparam logic [4:0]  user_page_off_instr  = 5'h0C;
  localparam logic [4:0]  INS_BYPASS    = 5'h1F;

  // ----------------------------------------------------------------
  // data registers and identity value (identity fields arbitrary)
  // ----------------------------------------------------------------
  localparam int          DR_W          = 32;
  localparam int          BYTE_W        = 8;
  localparam logic [3:0]  ID_VERSION    = 4'h2;
  localparam logic [15:0] ID_PART       = 16'h1234;
  localparam logic [10:0] ID_MAKER      = 11'h0A5;
  localparam logic [31:0] ID_VALUE      = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // ----------------------------------------------------------------
  // memory pages: upper two address bits
  // ----------------------------------------------------------------
  localparam int          MADDR_W       = 10;
  localparam logic [1:0]  PAGE_DEFAULT  = 2'h0;
  localparam logic [1:0]  PAGE_FLASH    = 2'h2;
  localparam logic [1:0]  PAGE_USER     = 2'h3;
  localparam logic [1:0]  SAVE_NOTHING  = 2'h3;

  // ----------------------------------------------------------------
  // operations passed from the link domain to the system domain
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_REFRESH, OP_LOAD, OP_WRITE, OP_REBOOT, OP_SAVE,
    OP_FLASH_ON, OP_FLASH_OFF, OP_USER_ON, OP_USER_OFF
  } jtm_op_t;

  typedef enum logic [1:0] {
    SYS_IDLE, SYS_ACT, SYS_READ
  } jtm_sys_st_t;

endpackage

//--- logic/jtm_tap.sv
// jtm_tap: test access port with instruction register, standard data
// registers and byte-wide memory access extensions.
// assumes tck_i is the link clock from an external controller; memory,
// reboot and save requests are served on sys_clk_i with mem_rdata_i
// valid in the same cycle as mem_rd_o.
//
// How it works
// [RQ1] exit1-IR goes to pause-IR or update-IR
// [RQ2] pause-IR holds shifter, TMS high to exit2
// [RQ3] exit2-IR goes to update-IR or shift-IR
// [RQ4] falling edge into update-IR latches instruction
// [RQ5] update-IR goes to idle or select-DR
// [RQ6] five-bit shifter plus five-bit latched output
// [RQ7] shift-IR shifts toward TDO with TMS low
// [RQ8] code 1F selects one-bit bypass
// [RQ9] code 00 captures and shifts identity value
// [RQ10] test-logic-reset forces identity instruction
// [RQ11] identity: one, maker, part, version fields
// [RQ12] code 03 captures user tag and slave id
// [RQ13] code 04 shifts eight-bit memory address
// [RQ14] code 05 shifts byte read at address
// [RQ15] code 06 writes shifted byte at address
// [RQ16] code 07 reboots and reloads from flash
// [RQ17] code 08 triggers fault-log save
// [RQ18] code 09 maps addresses onto flash page
// [RQ19] code 0A returns to default page
// [RQ20] code 0B user page only when flash on
// [RQ21] code 0C returns to flash page
// [RQ22] controller writes aligned eight-byte groups
// [RQ23] save control selects flags, readings, both, none
// [RQ24] capture-IR loads fixed value, then branches
// [RQ25] address advances after each write
// [RQ26] unknown codes behave as bypass
`timescale 1ns/100ps

module jtm_tap (
  input  wire logic        sys_clk_i,           // system clock
  input  wire logic        nrst_i,              // async reset, active low
  input  wire logic        tck_i,               // link clock
  input  wire logic        tms_i,               // mode select
  input  wire logic        tdi_i,               // serial data in
  output logic             tdo_o,               // serial data out
  output logic             tdo_oe_o,            // tdo drive enable
  input  wire logic [7:0]  user_tag_reg_i,      // stored user identifier
  input  wire logic [7:0]  slave_id_i,          // serial-bus slave identifier
  input  wire logic [1:0]  fault_log_control_i, // fault_log_control_reg[1:0]
  input  wire logic [7:0]  mem_rdata_i,         // memory read byte
  output logic [9:0]       mem_addr_o,          // page and byte address
  output logic [7:0]       mem_wdata_o,         // memory write byte
  output logic             mem_wr_o,            // write strobe, one cycle
  output logic             mem_rd_o,            // read strobe, one cycle
  output logic             reboot_o,            // reboot pulse, one cycle
  output logic             save_o,              // fault-log save pulse
  output logic [1:0]       save_sel_o,          // what the save stores
  output logic             flash_page_o,        // flash page mapped
  output logic             user_page_o          // user flash page mapped
);

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    jtm_pkg::jtm_tap_t st;
    logic [4:0]        ir_sh;
    logic [31:0]       dr;
    logic              req;
    jtm_pkg::jtm_op_t  op;
    logic [7:0]        data;
    logic              ack_s1;
    logic              ack_s2;
  } jtm_tck_t;

  typedef struct packed {
    logic [4:0] ir;
    logic       tdo;
    logic       oe;
  } jtm_neg_t;

  typedef struct packed {
    jtm_pkg::jtm_sys_st_t st;
    logic                 req_s1;
    logic                 req_s2;
    logic                 req_seen;
    logic                 ack;
    logic [7:0]           addr;
    logic                 flash_on;
    logic                 user_on;
    logic [7:0]           wdata;
    logic                 wr;
    logic                 rd;
    logic                 reboot;
    logic                 save;
    logic [1:0]           save_sel;
    logic [7:0]           snap_rd;
    logic [7:0]           snap_tag;
    logic [7:0]           snap_sid;
  } jtm_sys_rec_t;

  jtm_tck_t     t_q, t_d;
  jtm_neg_t     n_q, n_d;
  jtm_sys_rec_t s_q, s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic jtm_pkg::jtm_tap_t tap_next(input jtm_pkg::jtm_tap_t st, input logic tms);
    unique case (st)
      jtm_pkg::TAP_RESET:    tap_next = tms ? jtm_pkg::TAP_RESET    : jtm_pkg::TAP_IDLE;
      jtm_pkg::TAP_IDLE:     tap_next = tms ? jtm_pkg::TAP_SEL_DR   : jtm_pkg::TAP_IDLE;
      jtm_pkg::TAP_SEL_DR:   tap_next = tms ? jtm_pkg::TAP_SEL_IR   : jtm_pkg::TAP_CAP_DR;
      jtm_pkg::TAP_CAP_DR:   tap_next = tms ? jtm_pkg::TAP_EXIT1_DR : jtm_pkg::TAP_SHIFT_DR;
      jtm_pkg::TAP_SHIFT_DR: tap_next = tms ? jtm_pkg::TAP_EXIT1_DR : jtm_pkg::TAP_SHIFT_DR;
      jtm_pkg::TAP_EXIT1_DR: tap_next = tms ? jtm_pkg::TAP_UPD_DR   : jtm_pkg::TAP_PAUSE_DR;
      jtm_pkg::TAP_PAUSE_DR: tap_next = tms ? jtm_pkg::TAP_EXIT2_DR : jtm_pkg::TAP_PAUSE_DR;
      jtm_pkg::TAP_EXIT2_DR: tap_next = tms ? jtm_pkg::TAP_UPD_DR   : jtm_pkg::TAP_SHIFT_DR;
      jtm_pkg::TAP_UPD_DR:   tap_next = tms ? jtm_pkg::TAP_SEL_DR   : jtm_pkg::TAP_IDLE;
      jtm_pkg::TAP_SEL_IR:   tap_next = tms ? jtm_pkg::TAP_RESET    : jtm_pkg::TAP_CAP_IR;
      jtm_pkg::TAP_CAP_IR:   tap_next = tms ? jtm_pkg::TAP_EXIT1_IR : jtm_pkg::TAP_SHIFT_IR; // RQ24
      jtm_pkg::TAP_SHIFT_IR: tap_next = tms ? jtm_pkg::TAP_EXIT1_IR : jtm_pkg::TAP_SHIFT_IR;
      jtm_pkg::TAP_EXIT1_IR: tap_next = tms ? jtm_pkg::TAP_UPD_IR   : jtm_pkg::TAP_PAUSE_IR; // RQ1
      jtm_pkg::TAP_PAUSE_IR: tap_next = tms ? jtm_pkg::TAP_EXIT2_IR : jtm_pkg::TAP_PAUSE_IR; // RQ2
      jtm_pkg::TAP_EXIT2_IR: tap_next = tms ? jtm_pkg::TAP_UPD_IR   : jtm_pkg::TAP_SHIFT_IR; // RQ3
      jtm_pkg::TAP_UPD_IR:   tap_next = tms ? jtm_pkg::TAP_SEL_DR   : jtm_pkg::TAP_IDLE;     // RQ5
    endcase
  endfunction

  // selected data register length; anything unlisted is bypass
  function automatic logic [5:0] dr_len(input logic [4:0] ir);
    unique case (ir)
      jtm_pkg::INS_IDCODE, jtm_pkg::INS_USERCODE:                  dr_len = 6'd32;
      jtm_pkg::INS_LOAD_ADDR, jtm_pkg::INS_READ, jtm_pkg::INS_WRITE: dr_len = 6'd8;
      default:                                                     dr_len = 6'd1; // RQ8 RQ26
    endcase
  endfunction

  // shift toward bit 0, new bit enters at the top of the selected length
  function automatic logic [31:0] dr_shift(input logic [31:0] dr, input logic tdi, input logic [5:0] len);
    logic [31:0] r;
    r = dr >> 1;
    unique case (len)
      6'd32:   r[31] = tdi;
      6'd8:    r[7]  = tdi;
      default: r[0]  = tdi;
    endcase
    dr_shift = r;
  endfunction

  // ----------------------------------------------------------------
  // link domain, rising edge
  // ----------------------------------------------------------------
  always_comb begin
    t_d    = t_q;
    t_d.st = tap_next(t_q.st, tms_i);
    t_d.ack_s1 = s_q.ack;
    t_d.ack_s2 = t_q.ack_s1;
    unique case (t_q.st)
      jtm_pkg::TAP_CAP_IR:   t_d.ir_sh = jtm_pkg::IR_CAPTURE;                   // RQ24
      jtm_pkg::TAP_SHIFT_IR: t_d.ir_sh = {tdi_i, t_q.ir_sh[4:1]};              // RQ7
      jtm_pkg::TAP_CAP_DR: begin
        unique case (n_q.ir)
          jtm_pkg::INS_IDCODE:   t_d.dr = jtm_pkg::ID_VALUE;                   // RQ9 RQ11
          jtm_pkg::INS_USERCODE: t_d.dr = {16'h0000, s_q.snap_sid, s_q.snap_tag}; // RQ12
          jtm_pkg::INS_READ:     t_d.dr = {24'h000000, s_q.snap_rd};           // RQ14
          default:               t_d.dr = 32'h00000000;
        endcase
        // snapshot is only trusted once the last request is answered
        if (t_q.ack_s2 != t_q.req && (n_q.ir == jtm_pkg::INS_USERCODE || n_q.ir == jtm_pkg::INS_READ)) begin
          t_d.dr = t_q.dr;
        end
      end
      jtm_pkg::TAP_SHIFT_DR: t_d.dr = dr_shift(t_q.dr, tdi_i, dr_len(n_q.ir)); // RQ9 RQ13
      jtm_pkg::TAP_UPD_DR: begin
        if (n_q.ir == jtm_pkg::INS_LOAD_ADDR || n_q.ir == jtm_pkg::INS_WRITE) begin
          t_d.req  = ~t_q.req;
          t_d.data = t_q.dr[7:0];
          t_d.op   = (n_q.ir == jtm_pkg::INS_WRITE) ? jtm_pkg::OP_WRITE : jtm_pkg::OP_LOAD; // RQ13 RQ15
        end
      end
      jtm_pkg::TAP_UPD_IR: begin
        t_d.req = ~t_q.req;
        unique case (n_q.ir)
          jtm_pkg::INS_REBOOT:                t_d.op = jtm_pkg::OP_REBOOT;   // RQ16
          jtm_pkg::INS_SAVE:                  t_d.op = jtm_pkg::OP_SAVE;     // RQ17
          jtm_pkg::flash_page_on_instr:  t_d.op = jtm_pkg::OP_FLASH_ON;      // RQ18
          jtm_pkg::flash_page_off_instr: t_d.op = jtm_pkg::OP_FLASH_OFF;     // RQ19
          jtm_pkg::user_page_on_instr:   t_d.op = jtm_pkg::OP_USER_ON;       // RQ20
          jtm_pkg::user_page_off_instr:  t_d.op = jtm_pkg::OP_USER_OFF;      // RQ21
          default:                            t_d.op = jtm_pkg::OP_REFRESH;
        endcase
      end
      default: ; // pause-IR and others hold the shifter (RQ2)
    endcase
  end

  always_ff @(posedge tck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t_q <= '{st: jtm_pkg::TAP_RESET, op: jtm_pkg::OP_REFRESH, default: '0};
    end else begin
      t_q <= t_d;
    end
  end

  // ----------------------------------------------------------------
  // link domain, falling edge: instruction latch and tdo
  // ----------------------------------------------------------------
  always_comb begin
    n_d     = n_q;
    n_d.oe  = 1'b0;
    if (t_q.st == jtm_pkg::TAP_RESET) begin
      n_d.ir = jtm_pkg::INS_IDCODE;                                          // RQ10
    end else if (t_q.st == jtm_pkg::TAP_UPD_IR) begin
      n_d.ir = t_q.ir_sh;                                                    // RQ4 RQ6
    end
    if (t_q.st == jtm_pkg::TAP_SHIFT_IR) begin
      n_d.tdo = t_q.ir_sh[0];                                                // RQ7
      n_d.oe  = 1'b1;
    end else if (t_q.st == jtm_pkg::TAP_SHIFT_DR) begin
      n_d.tdo = t_q.dr[0];                                                   // RQ8 RQ9
      n_d.oe  = 1'b1;
    end
  end

  always_ff @(negedge tck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n_q <= '{ir: jtm_pkg::INS_IDCODE, default: '0};
    end else begin
      n_q <= n_d;
    end
  end

  // ----------------------------------------------------------------
  // system domain: serve requests, then read back the current byte
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.req_s1 = t_q.req;
    s_d.req_s2 = s_q.req_s1;
    s_d.wr     = 1'b0;
    s_d.rd     = 1'b0;
    s_d.reboot = 1'b0;
    s_d.save   = 1'b0;
    unique case (s_q.st)
      jtm_pkg::SYS_IDLE: begin
        if (s_q.req_s2 != s_q.req_seen) begin
          s_d.req_seen = s_q.req_s2;
          s_d.st       = jtm_pkg::SYS_ACT;
          // op and data are stable: they changed with the toggle, two sync stages back
          unique case (t_q.op)
            jtm_pkg::OP_LOAD:  s_d.addr = t_q.data;                          // RQ13
            jtm_pkg::OP_WRITE: begin
              s_d.wr    = 1'b1;                                              // RQ15 RQ22
              s_d.wdata = t_q.data;
            end
            jtm_pkg::OP_REBOOT: begin
              s_d.reboot   = 1'b1;                                           // RQ16
              s_d.flash_on = 1'b0;
              s_d.user_on  = 1'b0;
            end
            jtm_pkg::OP_SAVE: begin
              s_d.save     = (fault_log_control_i != jtm_pkg::SAVE_NOTHING); // RQ17 RQ23
              s_d.save_sel = fault_log_control_i;
            end
            jtm_pkg::OP_FLASH_ON:  s_d.flash_on = 1'b1;                      // RQ18
            jtm_pkg::OP_FLASH_OFF: begin
              s_d.flash_on = 1'b0;                                           // RQ19
              s_d.user_on  = 1'b0;
            end
            jtm_pkg::OP_USER_ON:   s_d.user_on = s_q.flash_on;               // RQ20
            jtm_pkg::OP_USER_OFF:  s_d.user_on = 1'b0;                       // RQ21
            default: ;
          endcase
        end
      end
      jtm_pkg::SYS_ACT: begin
        if (s_q.wr) begin
          s_d.addr = s_q.addr + 8'h01;                                       // RQ25
        end
        s_d.rd = 1'b1;                                                       // RQ14
        s_d.st = jtm_pkg::SYS_READ;
      end
      jtm_pkg::SYS_READ: begin
        s_d.snap_rd  = mem_rdata_i;
        s_d.snap_tag = user_tag_reg_i;                                       // RQ12
        s_d.snap_sid = slave_id_i;
        s_d.ack      = s_q.req_seen;
        s_d.st       = jtm_pkg::SYS_IDLE;
      end
      default: s_d.st = jtm_pkg::SYS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{st: jtm_pkg::SYS_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  logic [1:0] page_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_q <= jtm_pkg::PAGE_DEFAULT;
    end else begin
      page_q <= s_d.user_on ? jtm_pkg::PAGE_USER :
                (s_d.flash_on ? jtm_pkg::PAGE_FLASH : jtm_pkg::PAGE_DEFAULT); // RQ18 RQ20
    end
  end

  assign tdo_o        = n_q.tdo;
  assign tdo_oe_o     = n_q.oe;
  assign mem_addr_o   = {page_q, s_q.addr};
  assign mem_wdata_o  = s_q.wdata;
  assign mem_wr_o     = s_q.wr;
  assign mem_rd_o     = s_q.rd;
  assign reboot_o     = s_q.reboot;
  assign save_o       = s_q.save;
  assign save_sel_o   = s_q.save_sel;
  assign flash_page_o = s_q.flash_on;
  assign user_page_o  = s_q.user_on;

endmodule

//--- verification/jtm_tap_sva.sv
// jtm_tap_sva: port-level assertions for jtm_tap, bound into every instance.
// assumes nrst_i resets both domains and sys pulses last one cycle.
`timescale 1ns/100ps

module jtm_tap_sva (
  input wire logic       sys_clk_i,           // system clock
  input wire logic       nrst_i,              // async reset, active low
  input wire logic       tck_i,               // link clock
  input wire logic       tms_i,               // mode select
  input wire logic       tdo_oe_o,            // tdo drive enable
  input wire logic [1:0] fault_log_control_i, // save selection
  input wire logic [9:0] mem_addr_o,          // page and byte address
  input wire logic       mem_wr_o,            // write strobe
  input wire logic       mem_rd_o,            // read strobe
  input wire logic       reboot_o,            // reboot pulse
  input wire logic       save_o,              // save pulse
  input wire logic [1:0] save_sel_o,          // what the save stores
  input wire logic       flash_page_o,        // flash page mapped
  input wire logic       user_page_o          // user page mapped
);
  // ----------------------------------------------------------------
  // helper: address of the last write, to judge the step after it
  // ----------------------------------------------------------------
  logic [9:0] wr_addr_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_addr_q <= 10'h000;
    end else if (mem_wr_o) begin
      wr_addr_q <= mem_addr_o;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_wr_pulse_once: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    mem_wr_o |=> !mem_wr_o) else $error("write strobe longer than one cycle");
  a_addr_steps_wr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    mem_wr_o |-> ##[1:4] (mem_addr_o == {wr_addr_q[9:8], wr_addr_q[7:0] + 8'h01}))
    else $error("address did not advance after a write");
  a_rd_after_wr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    mem_wr_o |-> ##[1:4] mem_rd_o) else $error("no refresh read after a write");
  a_user_needs_flash: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    user_page_o |-> flash_page_o) else $error("user page mapped without flash page");
  a_save_sel_follows: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    save_o |-> ##[0:1] (save_sel_o == fault_log_control_i)) else $error("save selection wrong");
  a_save_pulse_once: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    save_o |=> !save_o) else $error("save pulse longer than one cycle");
  a_reboot_clears_pages: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    reboot_o |-> ##[0:2] (!flash_page_o && !user_page_o)) else $error("reboot kept a page");
  a_oe_off_reset: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tms_i [*5] |=> !tdo_oe_o) else $error("tdo driven after five tms high");
  a_oe_in_shift: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tms_i [*5] ##1 !tms_i ##1 tms_i [*2] ##1 (!tms_i) [*2] |=> tdo_oe_o)
    else $error("tdo not driven in shift-IR");
endmodule

bind jtm_tap jtm_tap_sva i_jtm_tap_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_oe_o(tdo_oe_o),
  .fault_log_control_i(fault_log_control_i), .mem_addr_o(mem_addr_o), .mem_wr_o(mem_wr_o),
  .mem_rd_o(mem_rd_o), .reboot_o(reboot_o), .save_o(save_o), .save_sel_o(save_sel_o),
  .flash_page_o(flash_page_o), .user_page_o(user_page_o));

//--- verification/jtm_ctl_model.sv
// jtm_ctl_model: behavioural external test controller driving the link.
// assumes the tap samples on rising tck and moves tdo on falling tck.
`timescale 1ns/100ps

module jtm_ctl_model (
  output logic      tck_o, // link clock, still between scans
  output logic      tms_o, // mode select
  output logic      tdi_o, // serial data to the tap
  input  wire logic tdo_i  // serial data from the tap
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // one 32 ns link cycle; tms/tdi change only while tck is low
  task automatic clk(input logic ms, input logic di, output logic so);
    tms_o = ms;
    tdi_o = di;
    #16;
    so = tdo_i;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask

  // full scan from idle back to idle, optionally through the pause loop
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic pz,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    clk(1'b1, 1'b0, b);
    if (ir) clk(1'b1, 1'b0, b);
    clk(1'b0, 1'b0, b);
    clk(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], b);
      dout[i] = b;
    end
    if (pz) begin
      clk(1'b0, 1'b0, b);
      clk(1'b0, 1'b0, b);
      clk(1'b1, 1'b0, b);
    end
    clk(1'b1, 1'b0, b);
    // idle cycles leave the sys side time to serve the request
    repeat (5) clk(1'b0, 1'b0, b);
  endtask

  task automatic tap_reset;
    logic b;
    repeat (5) clk(1'b1, 1'b0, b);
    clk(1'b0, 1'b0, b);
  endtask
endmodule

//--- verification/tb_top.sv
// tb_top: self-checking bench for jtm_tap with a behavioural link controller.
// assumes a memory whose byte is a function of address and page.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  logic        sys_clk_i, nrst_i, tck, tms, tdi, tdo, tdo_oe;
  logic [7:0]  tag, sid, rdata, wdata, a, p;
  logic [1:0]  flc, sel;
  logic [9:0]  addr;
  logic        wr, rd, reboot, save, fpg, upg;
  logic [35:0] sq[$], cq[$];
  logic [31:0] d, scan_v;
  logic [4:0]  bp[3] = '{5'h1F, 5'h01, 5'h0D};
  logic [4:0]  pc[5] = '{jtm_pkg::user_page_on_instr, jtm_pkg::flash_page_on_instr,
                         jtm_pkg::user_page_on_instr, jtm_pkg::user_page_off_instr,
                         jtm_pkg::flash_page_off_instr};
  logic [1:0]  pf[5] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h0};
  int          mismatches, checked, cycles;
  event        scan_ev;

  jtm_tap i_jtm_tap (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .user_tag_reg_i(tag), .slave_id_i(sid),
    .fault_log_control_i(flc), .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_wdata_o(wdata),
    .mem_wr_o(wr), .mem_rd_o(rd), .reboot_o(reboot), .save_o(save), .save_sel_o(sel),
    .flash_page_o(fpg), .user_page_o(upg));
  jtm_ctl_model i_jtm_ctl_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  // ----------------------------------------------------------------
  // clock, memory, watchdog and result watchers
  // ----------------------------------------------------------------
  always #5 sys_clk_i = ~sys_clk_i;
  // page bits folded into the data so a wrong page shows up on reads
  always @(negedge sys_clk_i) rdata <= addr[7:0] ^ {addr[9:8], 6'h1A};
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  always @(scan_ev) take({4'h1, scan_v}, 1'b0);
  // pulses are looked at mid-cycle, away from the edge that launches them
  always @(negedge sys_clk_i) begin
    if (wr === 1'b1) take({4'h2, 14'h0, addr, wdata}, 1'b1);
    if (save === 1'b1) take({4'h3, 30'h0, sel}, 1'b1);
    if (reboot === 1'b1) take({4'h4, 32'h0}, 1'b1);
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic take(input logic [35:0] got, input logic sy);
    logic [35:0] e;
    e = 36'hF_FFFF_FFFF;
    if (sy && sq.size() != 0) e = sq.pop_front();
    if (!sy && cq.size() != 0) e = cq.pop_front();
    `CHK(got, e)
  endtask
  task automatic ir(input logic [4:0] c, input logic pz);
    cq.push_back({4'h1, 32'h1});
    i_jtm_ctl_model.scan(1'b1, 5, {27'h0, c}, pz, d);
    scan_v = d;
    -> scan_ev;
  endtask
  task automatic dr(input int n, input logic [31:0] din, input logic [31:0] e, input logic chk);
    if (chk) cq.push_back({4'h1, e});
    i_jtm_ctl_model.scan(1'b0, n, din, 1'b0, d);
    if (chk) begin
      scan_v = d;
      -> scan_ev;
    end
  endtask
  task automatic load(input logic [7:0] ad);
    ir(jtm_pkg::INS_LOAD_ADDR, 1'b0);
    dr(8, {24'h0, ad}, 32'h0, 1'b0);
  endtask
  task automatic wr_byte(input logic [9:0] ad, input logic [7:0] b);
    sq.push_back({4'h2, 14'h0, ad, b});
    dr(8, {24'h0, b}, 32'h0, 1'b0);
  endtask
  task automatic pg(input logic [1:0] f);
    `CHK({fpg, upg}, f)
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    nrst_i = 1'b0;
    tag = 8'h00;
    sid = 8'h00;
    flc = 2'h0;
    rdata = 8'h00;
    void'($urandom(96));
    // link side needs a tck edge inside reset
    fork
      repeat (5) @(negedge sys_clk_i);
      i_jtm_ctl_model.clk(1'b1, 1'b0, p[0]);
    join
    nrst_i = 1'b1;
    i_jtm_ctl_model.tap_reset();
    @(negedge sys_clk_i);
    tag = 8'($urandom());
    sid = 8'($urandom());
    ir(jtm_pkg::INS_USERCODE, 1'b1);
    dr(32, 32'h0, {16'h0, sid, tag}, 1'b1);
    for (int i = 0; i < 3; i++) begin
      p = 8'($urandom());
      ir(bp[i], 1'b0);
      dr(8, {24'h0, p}, {24'h0, p[6:0], 1'b0}, 1'b1);
    end
    ir(jtm_pkg::INS_IDCODE, 1'b0);
    dr(32, 32'hFFFF_FFFF, jtm_pkg::ID_VALUE, 1'b1);
    a = {5'($urandom_range(29, 0)), 3'b000};
    load(a);
    ir(jtm_pkg::INS_WRITE, 1'b0);
    for (int i = 0; i < 8; i++) wr_byte({2'b00, a + 8'(i)}, 8'($urandom()));
    for (int i = 0; i < 5; i++) begin
      ir(pc[i], 1'b0);
      pg(pf[i]);
      load(a);
      ir(jtm_pkg::INS_READ, 1'b0);
      dr(8, 32'h0, {24'h0, a ^ {pf[i], 6'h1A}}, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_i);
      flc = 2'(i);
      if (i != 3) sq.push_back({4'h3, 30'h0, 2'(i)});
      ir(jtm_pkg::INS_SAVE, 1'b0);
    end
    ir(jtm_pkg::flash_page_on_instr, 1'b0);
    sq.push_back({4'h4, 32'h0});
    ir(jtm_pkg::INS_REBOOT, 1'b0);
    pg(2'h0);
    ir(jtm_pkg::INS_BYPASS, 1'b0);
    i_jtm_ctl_model.tap_reset();
    dr(32, 32'h0, jtm_pkg::ID_VALUE, 1'b1);
    repeat (20) @(negedge sys_clk_i);
    `CHK(sq.size() + cq.size(), 0)
    print_verdict();
  end
endmodule
